// *** hw/pclcl_top.sv ***
// single-wire pulse-count configuration link, gain sequencer and axi4-lite slave
// How it works
// - after power-up the gain sequencer starts at 1x and stays while regulation holds
// - regulation failing at 1x steps gain to 1.33x after the filter delay
// - regulation still failing at 1.33x steps gain to 1.5x after the filter delay
// - regulation still failing at 1.5x steps gain to 2x, the top gain
// - sufficient supply returns gain straight to 1x; no other downward step
// - undervoltage disables all channels and clears every configuration register
// - first high after shutdown enables the device with all currents zero
// - line low longer than 1.5 ms requests shutdown; device goes to zero current
// - in shutdown every led sink is high impedance with zero current
// - six configuration registers, five of four bits and one single bit
// - a write is an address burst then a separate data burst, in that order
// - falling edges are counted; N address pulses select register N, 1 to 6
// - pulse phases are 200 ns to 100 us; shorter pulses are ignored
// - no data edge within 1000 us after address abandons the transaction
// - selecting a register clears it to zero at once
// - after power-up the device awaits an address; host allows 10 us first
// - after a shutdown request currents stop after about 1 ms, registers lost
// - four-bit registers take (16 minus pulse count) modulo 16
// - register 1 bit 3 selects current range, bits 2..0 enable banks A, B, C
// - register 6 is 1 after one pulse, else 0; when 1, no automatic return to 1x
// - addressing register 6 restarts the gain sequencer from 1x
`timescale 1ns/100ps
`default_nettype none
module pclcl_top #(
  parameter int unsigned DATA_WAIT_CYC   = pclcl_pkg::DATA_WAIT_CYC,
  parameter int unsigned PHASE_MAX_CYC   = pclcl_pkg::PHASE_MAX_CYC,
  parameter int unsigned OFF_TIME_CYC    = pclcl_pkg::OFF_TIME_CYC,
  parameter int unsigned PWR_DOWN_CYC    = pclcl_pkg::PWR_DOWN_CYC,
  parameter int unsigned GAIN_FILTER_CYC = pclcl_pkg::GAIN_FILTER_CYC
) (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // single wire and analog indications
  input  wire logic        en_set,
  input  wire logic        uvlo,
  input  wire logic        regulation_fail,
  input  wire logic        supply_sufficient,
  // driver controls
  output var  logic [5:0]  led_sink_outputs,
  output var  logic        led_sink_hiz,
  output var  logic [1:0]  gain_select,
  output var  logic        device_enabled,
  output var  logic        current_range_select,
  output var  logic        bank_a_enable,
  output var  logic        bank_b_enable,
  output var  logic        bank_c_enable,
  output var  logic [3:0]  global_current,
  output var  logic [3:0]  bank_a_current,
  output var  logic [3:0]  bank_b_current,
  output var  logic [3:0]  bank_c_current,
  output var  logic        return_lockout,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int unsigned PW = pclcl_pkg::PHASE_CNT_W;
  localparam logic [PW-1:0] LIM_PHASE = PW'(PHASE_MAX_CYC);
  localparam logic [PW-1:0] LIM_WAIT  = PW'(DATA_WAIT_CYC);
  localparam logic [PW-1:0] LIM_OFF   = PW'(OFF_TIME_CYC + PWR_DOWN_CYC);
  localparam logic [pclcl_pkg::GAIN_CNT_W-1:0] LIM_GAIN =
    pclcl_pkg::GAIN_CNT_W'(GAIN_FILTER_CYC);
  localparam logic [pclcl_pkg::GLITCH_CNT_W-1:0] LIM_GLITCH =
    pclcl_pkg::GLITCH_CNT_W'(pclcl_pkg::GLITCH_CYC);

  // register value from a data pulse count
  function automatic logic [3:0] data_value(input logic [2:0] sel, input logic [4:0] cnt);
    logic [4:0] neg;
    neg = 5'h0 - cnt;
    if (sel == 3'(pclcl_pkg::LOCKOUT_IDX + 1)) begin
      data_value = {3'h0, cnt == 5'h01};
    end else begin
      data_value = neg[3:0];
    end
  endfunction

  // ------------------------------------------------------------
  // line synchroniser, glitch filter and phase timer
  // ------------------------------------------------------------
  logic                 sync1_q, sync2_q, filt_q, filt_d;
  logic [pclcl_pkg::GLITCH_CNT_W-1:0] glt_q, glt_d;
  logic [PW-1:0]        ph_q, ph_d;
  logic                 fall, rise;

  always_comb begin
    filt_d = filt_q;
    glt_d  = '0;
    if (sync2_q != filt_q) begin
      glt_d = glt_q + 1'b1;
      if (glt_q == LIM_GLITCH - 1'b1) begin
        filt_d = sync2_q;
        glt_d  = '0;
      end
    end
    fall = filt_q & ~filt_d;
    rise = ~filt_q & filt_d;
    if (fall | rise) begin
      ph_d = '0;
    end else if (ph_q == LIM_OFF) begin
      ph_d = ph_q;
    end else begin
      ph_d = ph_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      filt_q  <= 1'b0;
      glt_q   <= '0;
      ph_q    <= '0;
    end else if (ce) begin
      sync1_q <= en_set;
      sync2_q <= sync1_q;
      filt_q  <= filt_d;
      glt_q   <= glt_d;
      ph_q    <= ph_d;
    end
  end

  // ------------------------------------------------------------
  // pulse receiver and configuration registers
  // ------------------------------------------------------------
  pclcl_pkg::pclcl_link_t ls_q, ls_d;
  logic [2:0] sel_q, sel_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] cfg_q [pclcl_pkg::NUM_CFG];
  logic [3:0] cfg_d [pclcl_pkg::NUM_CFG];
  logic       en_q, en_d;
  logic       gain_restart;
  logic       rx_en_q, sw_restart_q;
  logic       shut;

  always_comb begin
    ls_d  = ls_q;
    sel_d = sel_q;
    cnt_d = cnt_q;
    en_d  = en_q;
    cfg_d = cfg_q;
    gain_restart = sw_restart_q;
    shut = ~filt_q & (ph_q == LIM_OFF - 1'b1);
    case (ls_q)
      pclcl_pkg::LS_OFF: begin
        if (rise) begin
          en_d  = 1'b1;
          cnt_d = '0;
          ls_d  = pclcl_pkg::LS_ADDR;
        end
      end
      pclcl_pkg::LS_ADDR: begin
        if (fall && rx_en_q && cnt_q != 5'h1F) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (rise) begin
          en_d = 1'b1;
        end
        if (filt_q && ph_q == LIM_PHASE - 1'b1 && cnt_q != 5'h00) begin
          cnt_d = '0;
          if (cnt_q <= 5'(pclcl_pkg::NUM_CFG)) begin
            sel_d = cnt_q[2:0];
            cfg_d[cnt_q[2:0] - 3'h1] = pclcl_pkg::CFG_RESET;
            ls_d  = pclcl_pkg::LS_GAP;
            if (cnt_q[2:0] == 3'(pclcl_pkg::LOCKOUT_IDX + 1)) begin
              gain_restart = 1'b1;
            end
          end
        end
      end
      pclcl_pkg::LS_GAP: begin
        if (fall) begin
          cnt_d = 5'h01;
          ls_d  = pclcl_pkg::LS_DATA;
        end else if (ph_q == LIM_WAIT - 1'b1) begin
          ls_d = pclcl_pkg::LS_ADDR;
        end
      end
      pclcl_pkg::LS_DATA: begin
        if (fall && cnt_q != 5'h1F) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (filt_q && ph_q == LIM_PHASE - 1'b1) begin
          cfg_d[sel_q - 3'h1] = data_value(sel_q, cnt_q);
          cnt_d = '0;
          ls_d  = pclcl_pkg::LS_ADDR;
        end
      end
      default: ls_d = pclcl_pkg::LS_OFF;
    endcase
    if (shut || uvlo) begin
      ls_d  = pclcl_pkg::LS_OFF;
      en_d  = 1'b0;
      cnt_d = '0;
      sel_d = '0;
      for (int i = 0; i < pclcl_pkg::NUM_CFG; i++) begin
        cfg_d[i] = pclcl_pkg::CFG_RESET;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ls_q  <= pclcl_pkg::LS_ADDR;
      sel_q <= '0;
      cnt_q <= '0;
      en_q  <= 1'b0;
      for (int i = 0; i < pclcl_pkg::NUM_CFG; i++) begin
        cfg_q[i] <= pclcl_pkg::CFG_RESET;
      end
    end else if (ce) begin
      ls_q  <= ls_d;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      en_q  <= en_d;
      cfg_q <= cfg_d;
    end
  end

  // ------------------------------------------------------------
  // gain sequencer
  // ------------------------------------------------------------
  pclcl_pkg::pclcl_gain_t g_q, g_d;
  logic [pclcl_pkg::GAIN_CNT_W-1:0] gc_q, gc_d;
  logic lockout;

  always_comb begin
    lockout = cfg_q[pclcl_pkg::LOCKOUT_IDX][0];
    g_d  = g_q;
    gc_d = '0;
    if (gain_restart || shut || uvlo || ls_q == pclcl_pkg::LS_OFF) begin
      g_d = pclcl_pkg::G_1X;
    end else if (supply_sufficient && !lockout && g_q != pclcl_pkg::G_1X) begin
      g_d = pclcl_pkg::G_1X;
    end else if (regulation_fail && g_q != pclcl_pkg::G_2X) begin
      gc_d = gc_q + 1'b1;
      if (gc_q == LIM_GAIN - 1'b1) begin
        gc_d = '0;
        case (g_q)
          pclcl_pkg::G_1X:   g_d = pclcl_pkg::G_1X33;
          pclcl_pkg::G_1X33: g_d = pclcl_pkg::G_1X5;
          pclcl_pkg::G_1X5:  g_d = pclcl_pkg::G_2X;
          default:           g_d = g_q;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      g_q  <= pclcl_pkg::G_1X;
      gc_q <= '0;
    end else if (ce) begin
      g_q  <= g_d;
      gc_q <= gc_d;
    end
  end

  // ------------------------------------------------------------
  // driver outputs
  // ------------------------------------------------------------
  logic [5:0] led_d;
  logic [2:0] bank_en;
  assign bank_en = {cfg_q[0][pclcl_pkg::BANK_A_BIT], cfg_q[0][pclcl_pkg::BANK_B_BIT],
                    cfg_q[0][pclcl_pkg::BANK_C_BIT]};

  // channels 5,4 are bank a, 3,2 bank b, 1,0 bank c
  for (genvar i = 0; i < 6; i++) begin : g_led
    assign led_d[i] = en_d & bank_en[i/2] & (ls_d != pclcl_pkg::LS_OFF);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      led_sink_outputs <= '0;
      led_sink_hiz     <= 1'b1;
      gain_select      <= 2'h0;
      device_enabled   <= 1'b0;
    end else if (ce) begin
      led_sink_outputs <= led_d;
      led_sink_hiz     <= ls_d == pclcl_pkg::LS_OFF;
      gain_select      <= g_d;
      device_enabled   <= en_d;
    end
  end

  assign current_range_select = cfg_q[0][pclcl_pkg::RANGE_BIT];
  assign bank_a_enable        = bank_en[2];
  assign bank_b_enable        = bank_en[1];
  assign bank_c_enable        = bank_en[0];
  assign global_current       = cfg_q[1];
  assign bank_a_current       = cfg_q[2];
  assign bank_b_current       = cfg_q[3];
  assign bank_c_current       = cfg_q[4];
  assign return_lockout       = lockout;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic        awg_q, awg_d, wg_q, wg_d, bv_d, rv_d, rx_en_d, swr_d, ws_q, ws_d;
  logic [3:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_d;
  logic [1:0]  br_d, rr_d;

  always_comb begin
    awg_d   = awg_q;
    wg_d    = wg_q;
    awa_d   = awa_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    bv_d    = s_axi_bvalid & ~s_axi_bready;
    br_d    = s_axi_bresp;
    rv_d    = s_axi_rvalid & ~s_axi_rready;
    rd_d    = s_axi_rdata;
    rr_d    = s_axi_rresp;
    rx_en_d = rx_en_q;
    swr_d   = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      awg_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wg_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb[0];
    end
    if (awg_d && wg_d && !bv_d) begin
      awg_d = 1'b0;
      wg_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = pclcl_pkg::RESP_OKAY;
      if ({awa_d[3:2], 2'h0} == pclcl_pkg::ADDR_CTRL) begin
        if (ws_d) begin
          rx_en_d = wd_d[pclcl_pkg::CTRL_RX_EN_BIT];
          swr_d   = wd_d[pclcl_pkg::CTRL_RESTART_BIT];
        end
      end else if ({awa_d[3:2], 2'h0} != pclcl_pkg::ADDR_CFG &&
                   {awa_d[3:2], 2'h0} != pclcl_pkg::ADDR_STATUS) begin
        br_d = pclcl_pkg::RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = pclcl_pkg::RESP_OKAY;
      rd_d = '0;
      case ({s_axi_araddr[3:2], 2'h0})
        pclcl_pkg::ADDR_CFG:
          rd_d[20:0] = {cfg_q[5][0], cfg_q[4], cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
        pclcl_pkg::ADDR_STATUS: begin
          rd_d[1:0] = g_q;
          rd_d[pclcl_pkg::ST_ENABLED_BIT]  = en_q;
          rd_d[pclcl_pkg::ST_SHUTDOWN_BIT] = ls_q == pclcl_pkg::LS_OFF;
          rd_d[pclcl_pkg::ST_SEL_LSB +: 3] = sel_q;
        end
        pclcl_pkg::ADDR_CTRL: rd_d[pclcl_pkg::CTRL_RX_EN_BIT] = rx_en_q;
        default: rr_d = pclcl_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awg_q <= 1'b0;
      wg_q  <= 1'b0;
      awa_q <= 4'h0;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 1'b0;
      rx_en_q <= pclcl_pkg::CTRL_RX_EN_RST;
      sw_restart_q  <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (ce) begin
      awg_q <= awg_d;
      wg_q  <= wg_d;
      awa_q <= awa_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      rx_en_q <= rx_en_d;
      sw_restart_q  <= swr_d;
      s_axi_awready <= ~awg_d & ~bv_d;
      s_axi_wready  <= ~wg_d & ~bv_d;
      s_axi_bvalid  <= bv_d;
      s_axi_bresp   <= br_d;
      s_axi_arready <= ~rv_d;
      s_axi_rvalid  <= rv_d;
      s_axi_rdata   <= rd_d;
      s_axi_rresp   <= rr_d;
    end
  end
endmodule
`default_nettype wire

// *** pkg/pclcl_pkg.sv ***
// constants and types of the pulse-count led configuration link
`default_nettype none
package pclcl_pkg;
  // ------------------------------------------------------------
  // timing, in ns, and derived cycle counts at core_clk
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned GLITCH_NS       = 200;
  localparam int unsigned PHASE_MAX_NS    = 100_000;
  localparam int unsigned DATA_WAIT_NS    = 1_000_000;
  localparam int unsigned OFF_TIME_NS     = 1_500_000;
  localparam int unsigned PWR_DOWN_NS     = 1_000_000;
  localparam int unsigned GAIN_FILTER_NS  = 400_000;
  localparam int unsigned GLITCH_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PHASE_MAX_CYC   = PHASE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned DATA_WAIT_CYC   = DATA_WAIT_NS / CLK_PERIOD_NS;
  localparam int unsigned OFF_TIME_CYC    = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWR_DOWN_CYC    = PWR_DOWN_NS / CLK_PERIOD_NS;
  localparam int unsigned GAIN_FILTER_CYC = GAIN_FILTER_NS / CLK_PERIOD_NS;
  localparam int unsigned PHASE_CNT_W     = 20;
  localparam int unsigned GAIN_CNT_W      = 20;
  localparam int unsigned GLITCH_CNT_W    = 6;
  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  localparam int unsigned NUM_CFG         = 6;
  localparam int unsigned LOCKOUT_IDX     = 5;
  localparam logic [3:0]  CFG_RESET       = 4'h0;
  localparam int unsigned RANGE_BIT       = 3;
  localparam int unsigned BANK_A_BIT      = 2;
  localparam int unsigned BANK_B_BIT      = 1;
  localparam int unsigned BANK_C_BIT      = 0;
  // ------------------------------------------------------------
  // axi4-lite register map
  // ------------------------------------------------------------
  localparam logic [3:0]  ADDR_CFG        = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_CTRL       = 4'h8;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int unsigned CTRL_RX_EN_BIT  = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam logic        CTRL_RX_EN_RST  = 1'b1;
  localparam int unsigned ST_ENABLED_BIT  = 2;
  localparam int unsigned ST_SHUTDOWN_BIT = 3;
  localparam int unsigned ST_SEL_LSB      = 8;
  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {LS_OFF, LS_ADDR, LS_GAP, LS_DATA} pclcl_link_t;
  typedef enum logic [1:0] {G_1X, G_1X33, G_1X5, G_2X} pclcl_gain_t;
endpackage
`default_nettype wire

// *** bench/pclcl_properties.sv ***
// concurrent checks on the outputs of the link block
`timescale 1ns/100ps
`default_nettype none
module pclcl_properties #(
  parameter int unsigned OFF_TIME_CYC    = 600,
  parameter int unsigned PWR_DOWN_CYC    = 200,
  parameter int unsigned GAIN_FILTER_CYC = 50
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // line and indications
  input wire logic       en_set,
  input wire logic       uvlo,
  input wire logic       regulation_fail,
  input wire logic       supply_sufficient,
  // driver controls
  input wire logic [5:0] led_sink_outputs,
  input wire logic       led_sink_hiz,
  input wire logic [1:0] gain_select,
  input wire logic       device_enabled,
  input wire logic [3:0] global_current,
  input wire logic       return_lockout,
  // bus
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_bvalid
);
  localparam int unsigned SHUT_CYC = OFF_TIME_CYC + PWR_DOWN_CYC + 60;
  logic [11:0] low_cnt_q, low_cnt_d, high_cnt_q, high_cnt_d, fail_cnt_q, fail_cnt_d;
  logic        en_q, en_d;
  // ----
  // run lengths of the line and of the regulation flag
  // ----
  always_comb begin
    low_cnt_d = en_set ? 12'h000 : low_cnt_q + {11'h000, low_cnt_q != 12'hFFF};
    high_cnt_d = 12'h000;
    if (en_set && !uvlo && (high_cnt_q != 12'h000 || !en_q)) begin
      high_cnt_d = high_cnt_q + {11'h000, high_cnt_q != 12'hFFF};
    end
    fail_cnt_d = regulation_fail ? fail_cnt_q + {11'h000, fail_cnt_q != 12'hFFF} : 12'h000;
    en_d = en_set;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt_q <= 12'h000;
      high_cnt_q <= 12'h000;
      fail_cnt_q <= 12'h000;
      en_q <= 1'b1;
    end else begin
      low_cnt_q <= low_cnt_d;
      high_cnt_q <= high_cnt_d;
      fail_cnt_q <= fail_cnt_d;
      en_q <= en_d;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_uvlo_held;
    uvlo ##1 uvlo ##1 uvlo;
  endsequence
  sequence s_step_up;
    $changed(gain_select) ##0 gain_select != 2'h0;
  endsequence
  a_hiz_no_sink: assert property (led_sink_hiz |-> led_sink_outputs == 6'h00)
    else $error("sinks on while outputs are high impedance");
  a_shutdown_clean: assert property (led_sink_hiz && !uvlo |->
    !device_enabled && global_current == 4'h0 && !return_lockout)
    else $error("shutdown kept enable or register contents");
  a_low_shutdown: assert property (low_cnt_q == SHUT_CYC |-> led_sink_hiz)
    else $error("long low level did not shut down");
  a_no_early_off: assert property ($rose(led_sink_hiz) && !uvlo && !$past(uvlo) |->
    low_cnt_q >= OFF_TIME_CYC)
    else $error("shutdown before the low time ran out");
  a_enable_high: assert property (high_cnt_q == 12'd80 |-> device_enabled)
    else $error("rising line did not enable");
  a_gain_order: assert property ($changed(gain_select) |->
    gain_select == pclcl_pkg::G_1X || gain_select == $past(gain_select) + 2'h1)
    else $error("gain skipped a state or stepped down");
  a_gain_filter: assert property (s_step_up |-> fail_cnt_q >= GAIN_FILTER_CYC - 1)
    else $error("gain rose before the filter delay");
  a_unity_return: assert property (supply_sufficient && !return_lockout && !regulation_fail
    && gain_select != 2'h0 |-> ##[1:2] gain_select == 2'h0)
    else $error("no return to unity gain");
  a_lockout_hold: assert property (return_lockout && gain_select != 2'h0 && !uvlo
    && !s_axi_awvalid && !s_axi_wvalid && !s_axi_bvalid
    |=> gain_select != 2'h0 || !return_lockout)
    else $error("gain returned to unity under lockout");
  a_uvlo_clears: assert property (s_uvlo_held |-> global_current == 4'h0
    && !device_enabled && led_sink_outputs == 6'h00 && !return_lockout)
    else $error("undervoltage left state behind");
endmodule
bind pclcl_top pclcl_properties #(.OFF_TIME_CYC(OFF_TIME_CYC), .PWR_DOWN_CYC(PWR_DOWN_CYC),
  .GAIN_FILTER_CYC(GAIN_FILTER_CYC)) props_u (.*);
`default_nettype wire

// *** bench/pclcl_host_model.sv ***
// host that drives pulse bursts on the single wire
`timescale 1ns/100ps
`default_nettype none
module pclcl_host_model #(
  parameter int unsigned PHASE_CYC = 60,
  parameter int unsigned GAP_CYC   = 250,
  parameter int unsigned TAIL_CYC  = 300
) (
  // clock
  input  wire logic core_clk,
  // single wire towards the device
  output var  logic en_set
);
  initial en_set = 1'b0;
  task automatic hold(input logic lvl, input int unsigned n);
    en_set <= lvl;
    repeat (n) @(posedge core_clk);
  endtask
  // each phase well above the glitch filter, below the end-of-burst time
  task automatic pulses(input int unsigned n);
    repeat (n) begin
      hold(1'b0, PHASE_CYC);
      hold(1'b1, PHASE_CYC);
    end
  endtask
  task automatic write_reg(input int unsigned a, input int unsigned d);
    pulses(a);
    hold(1'b1, GAP_CYC);
    pulses(d);
    hold(1'b1, TAIL_CYC);
  endtask
endmodule
`default_nettype wire

// *** bench/test_pulse_count_led_config_link.sv ***
// testbench of the pulse-count led configuration link
`timescale 1ns/100ps
`default_nettype none
module test_pulse_count_led_config_link;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, en_set, uvlo = 1'b0;
  logic regulation_fail = 1'b0, supply_sufficient = 1'b0;
  logic [5:0] led_sink_outputs;
  logic [1:0] gain_select;
  logic [3:0] global_current, bank_a_current, bank_b_current, bank_c_current;
  logic led_sink_hiz, device_enabled, current_range_select, return_lockout;
  logic bank_a_enable, bank_b_enable, bank_c_enable;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fails = 0;
  int comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  pclcl_top #(.DATA_WAIT_CYC(400), .PHASE_MAX_CYC(100), .OFF_TIME_CYC(600),
    .PWR_DOWN_CYC(200), .GAIN_FILTER_CYC(50)) dut_u (.*);
  pclcl_host_model host_u (.core_clk(core_clk), .en_set(en_set));
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int unsigned n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic gain_step(input int unsigned n);
    regulation_fail <= 1'b1;
    cyc(n);
    regulation_fail <= 1'b0;
    cyc(2);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300_000;
    fails++;
    end_of_test();
  end
  // ----
  // tests
  // ----
  initial begin
    logic [1:0] resp;
    logic [31:0] rd;
    int unsigned dlist [5] = '{0, 1, 2, 15, 16};
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    chk("gain", 32'h0, gain_select);
    chk("enabled", 32'h0, device_enabled);
    axi_rd(pclcl_pkg::ADDR_CTRL, rd, resp);
    chk("ctrl", 32'h1, rd);
    axi_rd(4'hC, rd, resp);
    chk("rresp", pclcl_pkg::RESP_SLVERR, resp);
    chk("rdata", 32'h0, rd);
    axi_wr(4'hC, 32'hFFFF_FFFF, resp);
    chk("bresp", pclcl_pkg::RESP_SLVERR, resp);
    cyc(100);
    host_u.hold(1'b1, 100);
    chk("enabled", 32'h1, device_enabled);
    chk("sinks", 32'h0, led_sink_outputs);
    $display("test reset done");
    foreach (dlist[i]) begin
      host_u.write_reg(2, dlist[i]);
      chk("global", 4'(16 - dlist[i]), global_current);
    end
    host_u.write_reg(1, 9);
    chk("range", 32'h0, current_range_select);
    chk("banks", 32'h7, {bank_a_enable, bank_b_enable, bank_c_enable});
    chk("sinks", 32'h3F, led_sink_outputs);
    host_u.write_reg(3, 2);
    host_u.write_reg(4, 3);
    host_u.write_reg(5, 15);
    chk("currents", 32'hED1, {bank_a_current, bank_b_current, bank_c_current});
    host_u.write_reg(6, 1);
    chk("lockout", 32'h1, return_lockout);
    axi_rd(pclcl_pkg::ADDR_CFG, rd, resp);
    chk("cfg", 32'h0011_DE07, rd);
    $display("test registers done");
    gain_step(60);
    chk("gain", 32'h1, gain_select);
    supply_sufficient <= 1'b1;
    cyc(5);
    chk("gain", 32'h1, gain_select);
    supply_sufficient <= 1'b0;
    axi_wr(pclcl_pkg::ADDR_CTRL, 32'h3, resp);
    cyc(2);
    chk("gain", 32'h0, gain_select);
    host_u.write_reg(6, 2);
    chk("lockout", 32'h0, return_lockout);
    gain_step(30);
    chk("gain", 32'h0, gain_select);
    ce <= 1'b0;
    gain_step(60);
    ce <= 1'b1;
    for (int g = 1; g <= 4; g++) begin
      gain_step(60);
      chk("gain", (g > 3) ? 3 : g, gain_select);
    end
    supply_sufficient <= 1'b1;
    cyc(5);
    chk("gain", 32'h0, gain_select);
    supply_sufficient <= 1'b0;
    host_u.write_reg(6, 1);
    gain_step(60);
    host_u.pulses(6);
    host_u.hold(1'b1, 500);
    chk("gain", 32'h0, gain_select);
    chk("lockout", 32'h0, return_lockout);
    $display("test gain done");
    host_u.pulses(3);
    host_u.hold(1'b1, 500);
    host_u.pulses(1);
    host_u.hold(1'b1, 500);
    chk("bank_a", 32'h0, bank_a_current);
    chk("bank_a_en", 32'h0, bank_a_enable);
    host_u.write_reg(2, 1);
    host_u.pulses(7);
    host_u.hold(1'b1, 600);
    chk("global", 32'hF, global_current);
    axi_rd(pclcl_pkg::ADDR_STATUS, rd, resp);
    chk("selected", 32'h2, rd[10:8]);
    axi_wr(pclcl_pkg::ADDR_CTRL, 32'h0, resp);
    host_u.write_reg(2, 3);
    chk("global", 32'hF, global_current);
    s_axi_wstrb <= 4'h0;
    axi_wr(pclcl_pkg::ADDR_CTRL, 32'h1, resp);
    axi_rd(pclcl_pkg::ADDR_CTRL, rd, resp);
    chk("ctrl", 32'h0, rd);
    s_axi_wstrb <= 4'hF;
    axi_wr(pclcl_pkg::ADDR_CTRL, 32'h1, resp);
    $display("test abandon done");
    host_u.hold(1'b0, 500);
    chk("hiz", 32'h0, led_sink_hiz);
    host_u.hold(1'b0, 400);
    chk("hiz", 32'h1, led_sink_hiz);
    chk("off", 32'h0, {device_enabled, global_current, led_sink_outputs});
    axi_rd(pclcl_pkg::ADDR_STATUS, rd, resp);
    chk("status_off", 32'h1, rd[3]);
    host_u.hold(1'b1, 100);
    chk("enabled", 32'h1, device_enabled);
    chk("sinks", 32'h0, led_sink_outputs);
    $display("test shutdown done");
    host_u.write_reg(2, 1);
    uvlo <= 1'b1;
    cyc(10);
    chk("uvlo", 32'h0, {device_enabled, global_current, led_sink_outputs});
    uvlo <= 1'b0;
    cyc(5);
    $display("test undervoltage done");
    end_of_test();
  end
endmodule
`default_nettype wire
